// [hw/hpp_dev.sv]
// Device end of the processor host port: turns host bus cycles into
// internal system bus accesses and terminates each cycle.
// Assumes a bus master that keeps its own protocol obligations.
module hpp_dev
    import hpp_pkg::*;
#(
    parameter int   DATA_W  = 32,
    parameter int   ADDR_W  = hpp_pkg::HPP_ADDR_W,
    parameter logic PAR_ODD = 1'b1
)(
    input  wire logic                          mclk_i,
    input  wire logic                          arst_n_i,
    input  wire logic                          ce_i,
    input  wire logic                          port_en_i,
    input  wire logic                          cfg_done_i,
    input  wire logic                          host_clk_sel_i,
    input  wire logic                          alt_sys_clk_i,
    output logic                               sys_clk_o,
    output logic                               sb_req_o,
    output logic                               sb_we_o,
    output logic                               sb_burst_o,
    output logic [ADDR_W-1:0]                  sb_addr_o,
    output logic [3:0]                         sb_be_o,
    output logic [31:0]                        sb_wdata_o,
    input  wire logic [31:0]                   sb_rdata_i,
    input  wire logic                          sb_done_i,
    input  wire logic                          sb_err_i,
    input  wire logic                          sb_retry_i,
    input  wire logic [hpp_pkg::HPP_GPIO_W-1:0] gpio_out_i,
    input  wire logic [hpp_pkg::HPP_GPIO_W-1:0] gpio_oe_n_i,
    output logic [hpp_pkg::HPP_GPIO_W-1:0]      gpio_in_o,
    hpp_if.dev                                 bus
);
    import hpp_pkg::*;

    // ------------------------------------------------------------
    // Port width
    // ------------------------------------------------------------
    localparam logic [3:0] LANE_EN = (DATA_W == 8)  ? 4'h1 :
                                     (DATA_W == 16) ? 4'h3 : 4'hF;
    localparam logic [1:0] A_MASK  = (DATA_W == 8)  ? 2'h0 :
                                     (DATA_W == 16) ? 2'h1 : 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_RESP
    } hpp_dev_state_t;

    typedef struct packed {
        hpp_dev_state_t    st;
        logic              rnw;
        logic              burst;
        logic [ADDR_W-1:0] addr;
        logic [3:0]        be;
        logic [31:0]       wdata;
        logic [31:0]       rdata;
        logic [3:0]        rpar;
        logic              ack_n;
        logic              tea_n;
        logic              rty_n;
    } hpp_dev_regs_t;

    localparam hpp_dev_regs_t REGS_RST = '{
        st:    ST_IDLE,
        rnw:   1'b0,
        burst: 1'b0,
        addr:  '0,
        be:    4'h0,
        wdata: HPP_RST_DATA,
        rdata: HPP_RST_DATA,
        rpar:  4'h0,
        ack_n: 1'b1,
        tea_n: 1'b1,
        rty_n: 1'b1
    };

    hpp_dev_regs_t r;
    hpp_dev_regs_t next_r;
    logic [3:0]    lanes;
    logic [3:0]    par_bad;
    logic          sb_end;

    // ------------------------------------------------------------
    // System bus clock source
    // ------------------------------------------------------------
    // Plain mux: the select takes effect at once, whatever the clock levels
    assign sys_clk_o = host_clk_sel_i ? mclk_i : alt_sys_clk_i;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    assign lanes   = hpp_lanes(bus.tsize, bus.addr[1:0] & A_MASK)
                   & LANE_EN;
    assign par_bad = (hpp_parity(bus.d, PAR_ODD) ^ bus.p) & lanes;
    assign sb_end  = sb_done_i | sb_err_i | sb_retry_i;

    always_comb
    begin
        next_r       = r;
        next_r.ack_n = 1'b1;
        next_r.tea_n = 1'b1;
        next_r.rty_n = 1'b1;
        case (r.st)
            ST_IDLE:
            begin
                // Cycle taken on the rising edge with strobe low
                if (port_en_i && !bus.strobe_n)
                begin
                    next_r.rnw   = bus.rnw;
                    next_r.burst = !bus.burst_n;
                    next_r.addr  = bus.addr;
                    next_r.be    = lanes;
                    next_r.wdata = bus.d;
                    if (!bus.rnw && (par_bad != 4'h0))
                    begin
                        next_r.tea_n = 1'b0;
                        next_r.st    = ST_RESP;
                    end
                    else
                    begin
                        next_r.st = ST_ACCESS;
                    end
                end
            end
            ST_ACCESS:
            begin
                if (sb_end)
                begin
                    // Error beats retry beats done; one answer only
                    next_r.tea_n = !sb_err_i;
                    next_r.rty_n = sb_err_i || !sb_retry_i;
                    next_r.ack_n = sb_err_i || sb_retry_i
                                   || !sb_done_i;
                    next_r.rdata = sb_rdata_i;
                    next_r.rpar  = hpp_parity(sb_rdata_i, PAR_ODD);
                    next_r.st    = ST_RESP;
                end
            end
            ST_RESP:
            begin
                next_r.st = ST_IDLE;
            end
            default:
            begin
                next_r = REGS_RST;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            r <= REGS_RST;
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // System bus side
    // ------------------------------------------------------------
    assign sb_req_o   = (r.st == ST_ACCESS);
    assign sb_we_o    = !r.rnw;
    assign sb_burst_o = r.burst;
    assign sb_addr_o  = r.addr;
    assign sb_be_o    = r.be;
    assign sb_wdata_o = r.wdata;

    // ------------------------------------------------------------
    // Pin drive
    // ------------------------------------------------------------
    logic [31:0] lane_bits;
    logic        rd_drive;

    assign lane_bits = {{8{r.be[3]}}, {8{r.be[2]}},
                        {8{r.be[1]}}, {8{r.be[0]}}};
    // Read data only with a normal acknowledge of a read
    assign rd_drive  = (r.st == ST_RESP) && r.rnw && !r.ack_n;

    always_comb
    begin
        bus.d_dev         = r.rdata;
        bus.p_dev         = r.rpar;
        bus.term_dev      = {r.rty_n, r.tea_n, r.ack_n};
        bus.d_dev_oe_n    = '1;
        bus.p_dev_oe_n    = '1;
        bus.term_dev_oe_n = '1;
        if (port_en_i)
        begin
            bus.term_dev_oe_n = 3'h0;
            if (rd_drive)
            begin
                bus.d_dev_oe_n = ~lane_bits;
                bus.p_dev_oe_n = ~(r.be & LANE_EN);
            end
        end
        else if (cfg_done_i)
        begin
            // Released as user I/O
            bus.d_dev         = gpio_out_i[HPP_PIN_DW-1:0];
            bus.p_dev         = gpio_out_i[HPP_GPIO_ACK-1:HPP_PIN_DW];
            bus.term_dev      = gpio_out_i[HPP_GPIO_RTY:HPP_GPIO_ACK];
            bus.d_dev_oe_n    = gpio_oe_n_i[HPP_PIN_DW-1:0];
            bus.p_dev_oe_n    = gpio_oe_n_i[HPP_GPIO_ACK-1:HPP_PIN_DW];
            bus.term_dev_oe_n = gpio_oe_n_i[HPP_GPIO_RTY:HPP_GPIO_ACK];
        end
    end

    assign gpio_in_o = {bus.term, bus.p, bus.d};

endmodule

// [hw/hpp_host.sv]
// Bus master end of the processor host port.
// Assumes a device end on the same rising-edge bus clock.
module hpp_host
    import hpp_pkg::*;
#(
    parameter int   DATA_W  = 32,
    parameter int   ADDR_W  = hpp_pkg::HPP_ADDR_W,
    parameter logic PAR_ODD = 1'b1
)(
    input  wire logic              mclk_i,
    input  wire logic              arst_n_i,
    input  wire logic              ce_i,
    input  wire logic              cmd_valid_i,
    output logic                   cmd_ready_o,
    input  wire logic              cmd_rnw_i,
    input  wire logic [1:0]        cmd_size_i,
    input  wire logic              cmd_burst_i,
    input  wire logic [ADDR_W-1:0] cmd_addr_i,
    input  wire logic [31:0]       cmd_wdata_i,
    output logic                   rsp_valid_o,
    output hpp_pkg::hpp_rsp_t      rsp_status_o,
    output logic [31:0]            rsp_rdata_o,
    hpp_if.host                    bus
);
    import hpp_pkg::*;

    localparam logic [3:0] LANE_EN = (DATA_W == 8)  ? 4'h1 :
                                     (DATA_W == 16) ? 4'h3 : 4'hF;
    localparam logic [1:0] A_MASK  = (DATA_W == 8)  ? 2'h0 :
                                     (DATA_W == 16) ? 2'h1 : 2'h3;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_STRB,
        ST_WAIT
    } hpp_host_state_t;

    typedef struct packed {
        hpp_host_state_t   st;
        logic              rnw;
        logic [1:0]        tsz;
        logic              burst;
        logic [ADDR_W-1:0] addr;
        logic [31:0]       wdata;
        logic [3:0]        be;
        logic              rsp_valid;
        hpp_rsp_t          rsp;
        logic [31:0]       rdata;
    } hpp_host_regs_t;

    localparam hpp_host_regs_t REGS_RST = '{
        st:        ST_IDLE,
        rnw:       1'b1,
        tsz:       HPP_TSZ_WORD,
        burst:     1'b0,
        addr:      '0,
        wdata:     HPP_RST_DATA,
        be:        4'h0,
        rsp_valid: 1'b0,
        rsp:       HPP_RSP_OK,
        rdata:     HPP_RST_DATA
    };

    hpp_host_regs_t r;
    hpp_host_regs_t next_r;
    logic [3:0]     par_bad;

    assign par_bad = (hpp_parity(bus.d, PAR_ODD) ^ bus.p) & r.be;

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb
    begin
        next_r           = r;
        next_r.rsp_valid = 1'b0;
        case (r.st)
            ST_IDLE:
            begin
                if (cmd_valid_i)
                begin
                    next_r.rnw   = cmd_rnw_i;
                    next_r.tsz   = cmd_size_i;
                    next_r.burst = cmd_burst_i;
                    next_r.addr  = cmd_addr_i;
                    next_r.wdata = cmd_wdata_i;
                    next_r.be    = hpp_lanes(cmd_size_i,
                                   cmd_addr_i[1:0] & A_MASK) & LANE_EN;
                    next_r.st    = ST_STRB;
                end
            end
            ST_STRB:
            begin
                next_r.st = ST_WAIT;
            end
            ST_WAIT:
            begin
                if (bus.term != 3'h7)
                begin
                    next_r.rsp_valid = 1'b1;
                    next_r.rdata     = bus.d;
                    next_r.st        = ST_IDLE;
                    if (!bus.term[1])
                    begin
                        next_r.rsp = HPP_RSP_ERR;
                    end
                    else if (!bus.term[2])
                    begin
                        // Caller gives up the bus and repeats the cycle
                        next_r.rsp = HPP_RSP_RETRY;
                    end
                    else if (r.rnw && (par_bad != 4'h0))
                    begin
                        next_r.rsp = HPP_RSP_PERR;
                    end
                    else
                    begin
                        next_r.rsp = HPP_RSP_OK;
                    end
                end
            end
            default:
            begin
                next_r = REGS_RST;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
        begin
            r <= REGS_RST;
        end
        else if (ce_i)
        begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Pins and user side
    // ------------------------------------------------------------
    logic strb;

    assign strb            = (r.st == ST_STRB);
    assign bus.addr        = r.addr;
    assign bus.strobe_n    = !strb;
    assign bus.rnw         = r.rnw;
    assign bus.tsize       = r.tsz;
    assign bus.burst_n     = !r.burst;
    assign bus.d_host      = r.wdata;
    assign bus.p_host      = hpp_parity(r.wdata, PAR_ODD);
    // Write data only in the strobe cycle; released for reads
    assign bus.d_host_oe_n = (strb && !r.rnw) ? 32'h0000_0000
                                              : 32'hFFFF_FFFF;
    assign bus.p_host_oe_n = (strb && !r.rnw) ? 4'h0 : 4'hF;
    assign cmd_ready_o     = (r.st == ST_IDLE);
    assign rsp_valid_o     = r.rsp_valid;
    assign rsp_status_o    = r.rsp;
    assign rsp_rdata_o     = r.rdata;

endmodule

// [hw/hpp_if.sv]
// Pins between the external bus master and the host port.
// Resolves each shared pin from the two ends; undriven pins pull up.
interface hpp_if #(
    parameter int ADDR_W = 18
);
    logic [ADDR_W-1:0] addr;
    logic              strobe_n;
    logic              rnw;
    logic [1:0]        tsize;
    logic              burst_n;
    logic [31:0]       d_host;
    logic [31:0]       d_host_oe_n;
    logic [3:0]        p_host;
    logic [3:0]        p_host_oe_n;
    logic [31:0]       d_dev;
    logic [31:0]       d_dev_oe_n;
    logic [3:0]        p_dev;
    logic [3:0]        p_dev_oe_n;
    logic [2:0]        term_dev;
    logic [2:0]        term_dev_oe_n;
    logic [31:0]       d;
    logic [3:0]        p;
    logic [2:0]        term;

    // ------------------------------------------------------------
    // Wire resolution
    // ------------------------------------------------------------
    assign d    = (~d_dev_oe_n & d_dev) | (~d_host_oe_n & d_host)
                | (d_dev_oe_n & d_host_oe_n);
    assign p    = (~p_dev_oe_n & p_dev) | (~p_host_oe_n & p_host)
                | (p_dev_oe_n & p_host_oe_n);
    assign term = term_dev | term_dev_oe_n;

    modport host (
        output addr, strobe_n, rnw, tsize, burst_n,
        output d_host, d_host_oe_n, p_host, p_host_oe_n,
        input  d, p, term
    );
    modport dev (
        input  addr, strobe_n, rnw, tsize, burst_n,
        output d_dev, d_dev_oe_n, p_dev, p_dev_oe_n,
        output term_dev, term_dev_oe_n,
        input  d, p, term
    );
endinterface

// [hw/hpp_pkg.sv]
// Shared constants, types and helpers of the processor host port.
// Assumes both ends run on one rising-edge bus clock.
package hpp_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int          HPP_PIN_DW   = 32;
    localparam int          HPP_PIN_PW   = 4;
    localparam int          HPP_ADDR_W   = 18;
    localparam int          HPP_GPIO_W   = HPP_PIN_DW + HPP_PIN_PW + 3;
    localparam int          HPP_GPIO_ACK = 36;
    localparam int          HPP_GPIO_TEA = 37;
    localparam int          HPP_GPIO_RTY = 38;
    localparam logic [31:0] HPP_RST_DATA = 32'h0000_0000;

    // ------------------------------------------------------------
    // Transfer size codes
    // ------------------------------------------------------------
    localparam logic [1:0]  HPP_TSZ_WORD = 2'h0;
    localparam logic [1:0]  HPP_TSZ_BYTE = 2'h1;
    localparam logic [1:0]  HPP_TSZ_HALF = 2'h2;

    typedef enum logic [1:0] {
        HPP_RSP_OK,
        HPP_RSP_ERR,
        HPP_RSP_RETRY,
        HPP_RSP_PERR
    } hpp_rsp_t;

    // Parity of each byte lane; lane 0 is data bits 7:0
    function automatic logic [3:0] hpp_parity(input logic [31:0] d,
                                              input logic        odd);
        logic [3:0] p;
        p = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            p[i] = (^d[8*i +: 8]) ^ odd;
        end
        return p;
    endfunction

    // Active byte lanes from size and low address bits
    function automatic logic [3:0] hpp_lanes(input logic [1:0] tsz,
                                             input logic [1:0] a);
        logic [3:0] be;
        be = 4'h0;
        case (tsz)
            HPP_TSZ_BYTE: be = 4'h1 << a;
            HPP_TSZ_HALF: be = a[1] ? 4'hC : 4'h3;
            default:      be = 4'hF;
        endcase
        return be;
    endfunction

endpackage

// [tb/hpp_monitor.sv]
// Pin checks between the host end and the device end of the port.
// Assumes resolved pins, odd parity and a 32-bit port.
module hpp_monitor (
    input  wire logic        mclk_i,
    input  wire logic        arst_n_i,
    input  wire logic        port_en_i,
    input  wire logic        strobe_n,
    input  wire logic [31:0] d,
    input  wire logic [3:0]  p,
    input  wire logic [31:0] d_dev_oe_n,
    input  wire logic [3:0]  p_dev_oe_n,
    input  wire logic [2:0]  term
);
    timeunit 1ns;
    timeprecision 100ps;

    logic       busy;
    logic [3:0] par;

    // Odd parity of each byte lane as seen on the wire
    assign par = {^d[31:24], ^d[23:16], ^d[15:8], ^d[7:0]} ^ 4'hF;

    // Open cycle: from strobe until its termination
    always_ff @(posedge mclk_i or negedge arst_n_i)
    begin
        if (!arst_n_i)
            busy <= 1'b0;
        else if (!strobe_n)
            busy <= 1'b1;
        else if (term != 3'h7)
            busy <= 1'b0;
    end

    // ----------
    // Assertions
    // ----------
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!arst_n_i);

    a_one_term: assert property (
        port_en_i |-> $countones(~term) <= 1)
        else $error("more than one termination at once");
    a_term_pulse: assert property (
        port_en_i && term != 3'h7 |=> term == 3'h7)
        else $error("termination held longer than one cycle");
    a_term_bound: assert property (
        port_en_i && !strobe_n |-> ##[1:64] term != 3'h7)
        else $error("cycle never terminated");
    a_no_stray: assert property (
        port_en_i && term != 3'h7 |-> busy)
        else $error("termination without an open cycle");
    a_strobe_pulse: assert property (
        !strobe_n |=> strobe_n)
        else $error("strobe longer than one cycle");
    a_rd_ack: assert property (
        port_en_i && d_dev_oe_n != '1 |-> term == 3'h6)
        else $error("device drives data without acknowledge");
    a_par_ack: assert property (
        port_en_i && p_dev_oe_n != 4'hF |-> term == 3'h6)
        else $error("device drives parity without acknowledge");
    a_lane_pair: assert property (
        port_en_i |-> d_dev_oe_n == {{8{p_dev_oe_n[3]}},
        {8{p_dev_oe_n[2]}}, {8{p_dev_oe_n[1]}}, {8{p_dev_oe_n[0]}}})
        else $error("data and parity lanes disagree");
    a_par_odd: assert property (
        port_en_i && p_dev_oe_n != 4'hF |->
        ((p ^ par) & ~p_dev_oe_n) == 4'h0)
        else $error("wrong parity on a driven lane");

    c_read_ack: cover property (d_dev_oe_n == 32'h0 && term == 3'h6);
    c_error: cover property (term == 3'h5);
    c_retry: cover property (term == 3'h3);
endmodule

// [tb/tb_top.sv]
// Testbench: host end and device end joined through the pin interface.
// Assumes a 250 MHz bus clock and a 32-bit port.
module tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    import hpp_pkg::*;

    logic        mclk, arst_n, ce, port_en, cfg_done, clk_sel, alt_clk;
    logic        sb_done, sb_err, sb_retry, sys_clk, sb_req, sb_we, sb_burst;
    logic        cmd_valid, cmd_rnw, cmd_burst, cmd_ready, rsp_valid;
    logic [1:0]  cmd_size;
    logic [3:0]  sb_be;
    logic [17:0] cmd_addr, sb_addr;
    logic [31:0] cmd_wdata, sb_rdata, sb_wdata, rsp_rdata;
    logic [38:0] gpio_out, gpio_oe_n, gpio_in;
    hpp_rsp_t    rsp_status;
    int          num_errors, compares;

    hpp_if hpp_if_inst ();

    hpp_dev #(.DATA_W(32)) hpp_dev_inst (.mclk_i(mclk), .arst_n_i(arst_n),
        .ce_i(ce), .port_en_i(port_en), .cfg_done_i(cfg_done),
        .host_clk_sel_i(clk_sel), .alt_sys_clk_i(alt_clk),
        .sys_clk_o(sys_clk), .sb_req_o(sb_req), .sb_we_o(sb_we),
        .sb_burst_o(sb_burst), .sb_addr_o(sb_addr), .sb_be_o(sb_be),
        .sb_wdata_o(sb_wdata), .sb_rdata_i(sb_rdata), .sb_done_i(sb_done),
        .sb_err_i(sb_err), .sb_retry_i(sb_retry), .gpio_out_i(gpio_out),
        .gpio_oe_n_i(gpio_oe_n), .gpio_in_o(gpio_in), .bus(hpp_if_inst));

    hpp_host #(.DATA_W(32)) hpp_host_inst (.mclk_i(mclk), .arst_n_i(arst_n),
        .ce_i(ce), .cmd_valid_i(cmd_valid), .cmd_ready_o(cmd_ready),
        .cmd_rnw_i(cmd_rnw), .cmd_size_i(cmd_size), .cmd_burst_i(cmd_burst),
        .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
        .rsp_valid_o(rsp_valid), .rsp_status_o(rsp_status),
        .rsp_rdata_o(rsp_rdata), .bus(hpp_if_inst));

    hpp_monitor hpp_monitor_inst (.mclk_i(mclk), .arst_n_i(arst_n),
        .port_en_i(port_en), .strobe_n(hpp_if_inst.strobe_n),
        .d(hpp_if_inst.d), .p(hpp_if_inst.p),
        .d_dev_oe_n(hpp_if_inst.d_dev_oe_n),
        .p_dev_oe_n(hpp_if_inst.p_dev_oe_n), .term(hpp_if_inst.term));

    // ----------
    // Helpers
    // ----------
    function automatic logic [3:0] lanes(input logic [1:0] sz,
                                         input logic [1:0] a);
        if (sz == 2'h1)
            return 4'h1 << a;
        if (sz == 2'h2)
            return a[1] ? 4'hC : 4'h3;
        return 4'hF;
    endfunction

    // Mode 0 done, 1 error, 2 retry, 3 all three at once
    function automatic hpp_rsp_t exp_status(input int mode);
        if (mode == 0)
            return HPP_RSP_OK;
        return (mode == 2) ? HPP_RSP_RETRY : HPP_RSP_ERR;
    endfunction

    function automatic logic pick(input int w);
        return (w == 0) ? cmd_ready : (w == 1) ? sb_req : rsp_valid;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        compares++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic wait_hi(input int w);
        int n;
        for (n = 0; n < 64 && pick(w) !== 1'b1; n++)
            @(negedge mclk);
        if (n == 64)
            check(32'h0, 32'h1, "handshake wait");
    endtask

    task automatic xfer(input logic rd, input logic [1:0] sz,
                        input logic [17:0] a, input int mode);
        logic [3:0]  be;
        logic [31:0] m;
        be = lanes(sz, a[1:0]);
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        @(negedge mclk);
        cmd_valid = 1'b1;
        cmd_rnw = rd;
        cmd_size = sz;
        cmd_addr = a;
        cmd_wdata = $urandom;
        cmd_burst = 1'($urandom_range(1));
        wait_hi(0);
        @(negedge mclk);
        cmd_valid = 1'b0;
        wait_hi(1);
        check(32'(sb_we), 32'(!rd), "sb_we");
        check(32'(sb_be), 32'(be), "sb_be");
        check(32'(sb_addr), 32'(a), "sb_addr");
        check(32'(sb_burst), 32'(cmd_burst), "sb_burst");
        if (!rd)
            check(sb_wdata & m, cmd_wdata & m, "sb_wdata");
        repeat ($urandom_range(2)) @(negedge mclk);
        if ($urandom_range(3) == 0)
        begin
            // Clock enable low: a done pulse must not be taken
            ce = 1'b0;
            sb_done = 1'b1;
            @(negedge mclk);
            {ce, sb_done} = 2'h2;
            check(32'(sb_req), 32'h1, "frozen request");
            @(negedge mclk);
        end
        sb_rdata = $urandom;
        sb_done = (mode == 0 || mode == 3);
        sb_err = (mode == 1 || mode == 3);
        sb_retry = (mode >= 2);
        @(negedge mclk);
        {sb_done, sb_err, sb_retry} = 3'h0;
        wait_hi(2);
        check(32'(rsp_status), 32'(exp_status(mode)), "status");
        if (rd && mode == 0)
            check(rsp_rdata & m, sb_rdata & m, "rdata");
    endtask

    // ----------
    // Stimulus
    // ----------
    initial
    begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    initial
    begin
        #100000;
        num_errors++;
        end_sim();
    end

    initial
    begin
        {ce, port_en, cfg_done, clk_sel, alt_clk} = 5'h1E;
        {sb_done, sb_err, sb_retry, cmd_valid, cmd_rnw, cmd_burst} = 6'h0;
        {cmd_size, cmd_addr, cmd_wdata, sb_rdata} = '0;
        gpio_out = '0;
        gpio_oe_n = '1;
        num_errors = 0;
        compares = 0;
        arst_n = 1'b0;
        void'($urandom(14783));
        repeat (2) @(negedge mclk);
        arst_n = 1'b1;
        // Every size at every byte offset, write and read
        for (int i = 0; i < 24; i++)
            xfer(i[0], 2'((i >> 1) % 3), {16'($urandom), 2'(i / 6)}, 0);
        // Each termination kind, then a repeat after all three at once
        for (int k = 0; k < 4; k++)
            xfer(1'b1, 2'h0, 18'h3FFFF, k);
        xfer(1'b1, 2'h0, 18'h3FFFF, 0);
        repeat (60)
            xfer(1'($urandom_range(1)), 2'($urandom_range(2)), 18'($urandom),
                 $urandom_range(3));
        @(posedge mclk);
        #1;
        check(32'(sys_clk), 32'h1, "sys clock");
        clk_sel = 1'b0;
        #0.5;
        check(32'(sys_clk), 32'h0, "alt clock");
        alt_clk = 1'b1;
        #0.2;
        check(32'(sys_clk), 32'h1, "alt clock high");
        @(negedge mclk);
        port_en = 1'b0;
        gpio_out = 39'($urandom);
        gpio_oe_n = {7'h7F, 32'h0};
        @(negedge mclk);
        check(hpp_if_inst.d, gpio_out[31:0], "user pins");
        check(gpio_in[31:0], gpio_out[31:0], "user input");
        cfg_done = 1'b0;
        @(negedge mclk);
        check(hpp_if_inst.d, 32'hFFFFFFFF, "pins before config");
        end_sim();
    end
endmodule
